// ===== logic/gds_port.sv
// Direction register, set and clear aliases, sense-hit record, detect styles.
// Assumes a single-cycle register port on clk and raw pin levels from outside.
//
// The implementer's own choice: the strobed register port.
`timescale 1ns/1ps
`include "gds_defs.svh"


module gds_port
(
  input  wire logic                   clk,
  input  wire logic                   reset_n,
  input  wire logic                   clk_en,
  input  gds_pkg::gds_bus_req_t       bus_req,
  output logic [31:0]                 rdata,
  input  wire logic [31:0]            pin_level,
  input  wire logic [63:0]            per_pin_sense,
  input  wire logic [31:0]            pin_secure,
  input  wire logic [31:0]            setup_dir_wdata,
  input  wire logic [31:0]            setup_dir_we,
  output logic [31:0]                 pin_dir,
  output gds_pkg::gds_detect_t        held_sense_event,
  output logic                        irq
);
  import gds_pkg::*;


  // ************************************************************
  // Declarations
  // ************************************************************
  logic [31:0]  lvl_meta_r;
  logic [31:0]  lvl_sync_r;
  logic [31:0]  dir_r;
  logic [31:0]  dir_nxt;
  logic [31:0]  hit_r;
  logic [31:0]  live_det;
  logic [31:0]  hit_clr;
  logic         ns_style_r;
  logic         s_style_r;
  logic [1:0]   irq_stat_r;
  logic [1:0]   irq_mask_r;
  logic [1:0]   det_prev_r;
  logic         det_ns;
  logic         det_s;
  logic         wr_dir;
  logic         wr_set;
  logic         wr_clr;
  logic         wr_hit;
  logic         wr_ns;
  logic         wr_s;
  logic         wr_ist;
  logic         wr_imk;
  logic [1:0]   det_rise;

  assign wr_dir = bus_req.wr && (bus_req.addr == `GDS_OFS_DIR);
  assign wr_set = bus_req.wr && (bus_req.addr == `GDS_OFS_DIR_SET);
  assign wr_clr = bus_req.wr && (bus_req.addr == `GDS_OFS_DIR_CLR);
  assign wr_hit = bus_req.wr && (bus_req.addr == `GDS_OFS_SENSE_HIT);
  assign wr_ns  = bus_req.wr && (bus_req.addr == `GDS_OFS_NS_STYLE);
  assign wr_s   = bus_req.wr && (bus_req.addr == `GDS_OFS_S_STYLE);
  assign wr_ist = bus_req.wr && (bus_req.addr == `GDS_OFS_IRQ_STATUS);
  assign wr_imk = bus_req.wr && (bus_req.addr == `GDS_OFS_IRQ_MASK);

  // ************************************************************
  // Pin synchroniser
  // ************************************************************
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      lvl_meta_r <= `GDS_RST_WORD;
      lvl_sync_r <= `GDS_RST_WORD;
    end
    else if (clk_en)
    begin
      lvl_meta_r <= pin_level;
      lvl_sync_r <= lvl_meta_r;
    end
  end

  // ************************************************************
  // Direction storage
  // ************************************************************
  always_comb
  begin
    dir_nxt = dir_r;
    if (wr_dir)
      dir_nxt = bus_req.wdata;
    if (wr_set)
      dir_nxt = dir_r | bus_req.wdata;
    if (wr_clr)
      dir_nxt = dir_r & ~bus_req.wdata;
    dir_nxt = (dir_nxt & ~setup_dir_we) | (setup_dir_wdata & setup_dir_we);
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
      dir_r <= `GDS_RST_WORD;
    else if (clk_en)
      dir_r <= dir_nxt;
  end

  assign pin_dir = dir_r;

  // ************************************************************
  // Sense-hit bits
  // ************************************************************
  assign hit_clr = wr_hit ? bus_req.wdata : 32'h00000000;

  genvar gi;
  generate
    for (gi = 0; gi < `GDS_PIN_COUNT; gi++)
    begin : g_pin
      gds_pin_sense u_sense
      (
        .clk     (clk),
        .reset_n (reset_n),
        .clk_en  (clk_en),
        .level   (lvl_sync_r[gi]),
        .sense   (gds_sense_t'(per_pin_sense[2*gi +: 2])),
        .clear   (hit_clr[gi]),
        .detect  (live_det[gi]),
        .hit_r   (hit_r[gi])
      );
    end
  endgenerate

  // ************************************************************
  // Detect styles
  // ************************************************************
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      ns_style_r <= 1'b0;
      s_style_r  <= 1'b0;
    end
    else if (clk_en)
    begin
      if (wr_ns)
        ns_style_r <= bus_req.wdata[`GDS_STYLE_BIT];
      if (wr_s)
        s_style_r <= bus_req.wdata[`GDS_STYLE_BIT];
    end
  end

  assign det_ns = ns_style_r ? |(hit_r & ~pin_secure) : |(live_det & ~pin_secure);
  assign det_s  = s_style_r  ? |(hit_r & pin_secure)  : |(live_det & pin_secure);

  always_ff @(posedge clk)
  begin
    if (!reset_n)
      held_sense_event <= '0;
    else if (clk_en)
    begin
      held_sense_event.nonsec <= det_ns;
      held_sense_event.sec    <= det_s;
    end
  end

  // ************************************************************
  // Interrupts
  // ************************************************************
  assign det_rise = {det_s, det_ns} & ~det_prev_r;

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      det_prev_r <= 2'h0;
      irq_stat_r <= 2'h0;
      irq_mask_r <= 2'h0;
    end
    else if (clk_en)
    begin
      det_prev_r <= {det_s, det_ns};
      irq_stat_r <= (irq_stat_r & ~(wr_ist ? bus_req.wdata[1:0] : 2'h0)) | det_rise;
      if (wr_imk)
        irq_mask_r <= bus_req.wdata[1:0];
    end
  end

  assign irq = |(irq_stat_r & irq_mask_r);

  // ************************************************************
  // Read port
  // ************************************************************
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      rdata <= `GDS_RST_WORD;
    else if (clk_en)
    begin
      rdata <= `GDS_RST_WORD;
      if (bus_req.rd)
      begin
        case (bus_req.addr)
          `GDS_OFS_DIR, `GDS_OFS_DIR_SET, `GDS_OFS_DIR_CLR: rdata <= dir_r;
          `GDS_OFS_SENSE_HIT:  rdata <= hit_r;
          `GDS_OFS_NS_STYLE:   rdata <= {31'h0, ns_style_r};
          `GDS_OFS_S_STYLE:    rdata <= {31'h0, s_style_r};
          `GDS_OFS_IRQ_STATUS: rdata <= {30'h0, irq_stat_r};
          `GDS_OFS_IRQ_MASK:   rdata <= {30'h0, irq_mask_r};
          default:             rdata <= `GDS_RST_WORD;
        endcase
      end
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************
  // set alias check
  chk_dir_set: assert property (@(posedge clk) disable iff (!reset_n)
    clk_en && wr_set && setup_dir_we == 32'h00000000 |=> dir_r == ($past(dir_r) | $past(bus_req.wdata)))
    else $error("set alias wrong");
  chk_dir_clr: assert property (@(posedge clk) disable iff (!reset_n)
    clk_en && wr_clr && setup_dir_we == 32'h00000000 |=> dir_r == ($past(dir_r) & ~$past(bus_req.wdata)))
    else $error("clear alias wrong");
  chk_dir_write: assert property (@(posedge clk) disable iff (!reset_n)
    clk_en && wr_dir && setup_dir_we == 32'h00000000 |=> dir_r == $past(bus_req.wdata))
    else $error("direction write lost");
  chk_alias_read: assert property (@(posedge clk) disable iff (!reset_n)
    clk_en && bus_req.rd && (bus_req.addr == `GDS_OFS_DIR_SET || bus_req.addr == `GDS_OFS_DIR_CLR)
    |=> rdata == $past(dir_r)) else $error("alias read wrong");
  chk_setup_dir: assert property (@(posedge clk) disable iff (!reset_n)
    clk_en && setup_dir_we != 32'h00000000 |=> ((dir_r ^ $past(setup_dir_wdata)) & $past(setup_dir_we)) == 32'h0)
    else $error("setup direction not shared");
  chk_ns_direct: assert property (@(posedge clk) disable iff (!reset_n)
    clk_en && !ns_style_r |=> held_sense_event.nonsec == |($past(live_det) & ~$past(pin_secure)))
    else $error("direct detect wrong");
  chk_ns_latched: assert property (@(posedge clk) disable iff (!reset_n)
    clk_en && ns_style_r |=> held_sense_event.nonsec == |($past(hit_r) & ~$past(pin_secure)))
    else $error("latched detect wrong");
  chk_s_latched: assert property (@(posedge clk) disable iff (!reset_n)
    clk_en && s_style_r && |(hit_r & pin_secure) |=> held_sense_event.sec)
    else $error("secure latched detect dropped");
  chk_s_style: assert property (@(posedge clk) disable iff (!reset_n)
    clk_en && wr_s |=> s_style_r == $past(bus_req.wdata[0]))
    else $error("secure style not stored");
  chk_dir_read: assert property (@(posedge clk) disable iff (!reset_n)
    clk_en && bus_req.rd && bus_req.addr == `GDS_OFS_DIR |=> rdata == $past(dir_r))
    else $error("direction read wrong");
  chk_hit_read: assert property (@(posedge clk) disable iff (!reset_n)
    clk_en && bus_req.rd && bus_req.addr == `GDS_OFS_SENSE_HIT |=> rdata == $past(hit_r))
    else $error("hit read wrong");
  chk_ns_style: assert property (@(posedge clk) disable iff (!reset_n)
    clk_en && wr_ns |=> ns_style_r == $past(bus_req.wdata[0]))
    else $error("non-secure style not stored");
  chk_ns_isolated: assert property (@(posedge clk) disable iff (!reset_n)
    clk_en && ns_style_r && (hit_r & ~pin_secure) == 32'h00000000 |=> !held_sense_event.nonsec)
    else $error("secure hit leaked to non-secure detect");
  chk_ns_held: assert property (@(posedge clk) disable iff (!reset_n)
    clk_en && ns_style_r && |(hit_r & ~pin_secure) |=> held_sense_event.nonsec)
    else $error("non-secure latched detect dropped");
  chk_s_direct: assert property (@(posedge clk) disable iff (!reset_n)
    clk_en && !s_style_r |=> held_sense_event.sec == |($past(live_det) & $past(pin_secure)))
    else $error("secure direct detect wrong");
  chk_dir_frozen: assert property (@(posedge clk) disable iff (!reset_n)
    !clk_en |=> $stable(dir_r))
    else $error("direction changed while frozen");
  chk_hit_frozen: assert property (@(posedge clk) disable iff (!reset_n)
    !clk_en |=> $stable(hit_r))
    else $error("hit changed while frozen");

endmodule

// ===== logic/gds_defs.svh
// Offsets, field positions and reset values of the direction and sense-hit block.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef GDS_DEFS_SVH
`define GDS_DEFS_SVH

`define GDS_PIN_COUNT        32
`define GDS_ADDR_W           12
`define GDS_OFS_DIR          12'h014
`define GDS_OFS_DIR_SET      12'h018
`define GDS_OFS_DIR_CLR      12'h01C
`define GDS_OFS_SENSE_HIT    12'h020
`define GDS_OFS_NS_STYLE     12'h024
`define GDS_OFS_S_STYLE      12'h028
`define GDS_OFS_IRQ_STATUS   12'h040
`define GDS_OFS_IRQ_MASK     12'h044
`define GDS_RST_WORD         32'h00000000
`define GDS_STYLE_BIT        0
`define GDS_SENSE_OFF        2'h0
`define GDS_SENSE_HIGH       2'h2
`define GDS_SENSE_LOW        2'h3
`define GDS_IRQ_NS_BIT       0
`define GDS_IRQ_S_BIT        1

`endif

// ===== logic/gds_pkg.sv
// Types shared by the direction and sense-hit block.
// Assumes gds_defs.svh is on the include path.
`include "gds_defs.svh"

package gds_pkg;

  typedef enum logic [1:0]
  {
    GDS_SENSE_DISABLED = 2'b00,
    GDS_SENSE_RSVD     = 2'b01,
    GDS_SENSE_HI       = 2'b10,
    GDS_SENSE_LO       = 2'b11
  } gds_sense_t;

  typedef struct packed
  {
    logic [`GDS_ADDR_W-1:0] addr;
    logic [31:0]            wdata;
    logic                   wr;
    logic                   rd;
  } gds_bus_req_t;

  typedef struct packed
  {
    logic nonsec;
    logic sec;
  } gds_detect_t;

endpackage

// ===== logic/gds_pin_sense.sv
// One pin's sense-hit bit and live detect term.
// Assumes a synchronised pin level and a one-cycle clear pulse on clk.
`timescale 1ns/1ps
`include "gds_defs.svh"

module gds_pin_sense
(
  input  wire logic           clk,
  input  wire logic           reset_n,
  input  wire logic           clk_en,
  input  wire logic           level,
  input  gds_pkg::gds_sense_t sense,
  input  wire logic           clear,
  output logic                detect,
  output logic                hit_r
);
  import gds_pkg::*;

  always_comb
  begin
    case (sense)
      GDS_SENSE_HI: detect = level;
      GDS_SENSE_LO: detect = ~level;
      default:      detect = 1'b0;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
      hit_r <= 1'b0;
    else if (clk_en)
    begin
      if (detect)
        hit_r <= 1'b1;
      else if (clear)
        hit_r <= 1'b0;
    end
  end

  chk_hit_clear: assert property (@(posedge clk) disable iff (!reset_n)
    clk_en && clear && !detect |=> !hit_r) else $error("hit not cleared");
  chk_hit_set: assert property (@(posedge clk) disable iff (!reset_n)
    clk_en && detect |=> hit_r) else $error("hit not set");

endmodule

// ===== tb/gds_pin_drv.sv
// Model of the outside circuitry that drives the port's pins.
// Assumes the bench orders new pin levels on clk.
`timescale 1ns/1ps

module gds_pin_drv (
  input  wire logic        clk,
  input  wire logic [31:0] want,
  output logic      [31:0] pin_level = '0
);
  // Levels settle one edge after the order
  always @(posedge clk)
    pin_level <= want;
endmodule

// ===== tb/tb_top.sv
// Self-checking bench for the direction and sense-hit block.
// Assumes gds_pkg and gds_defs.svh are compiled first.
`timescale 1ns/1ps
`include "gds_defs.svh"

module tb_top;
  import gds_pkg::*;
  logic         clk     = 1'b0;
  logic         reset_n = 1'b0;
  logic         ce      = 1'b1;
  gds_bus_req_t req     = '0;
  logic [31:0]  want    = '0;
  logic [31:0]  sec     = '0;
  logic [31:0]  sdw     = '0;
  logic [31:0]  sdwe    = '0;
  logic [63:0]  sense   = '0;
  logic [31:0]  rdata;
  logic [31:0]  pin_level;
  logic [31:0]  pin_dir;
  gds_detect_t  det;
  logic         irq;
  int           err_count   = 0;
  int           comparisons = 0;

  always #25 clk = ~clk;

  gds_pin_drv drv (.clk(clk), .want(want), .pin_level(pin_level));

  gds_port dut (
    .clk(clk), .reset_n(reset_n), .clk_en(ce), .bus_req(req), .rdata(rdata),
    .pin_level(pin_level), .per_pin_sense(sense), .pin_secure(sec),
    .setup_dir_wdata(sdw), .setup_dir_we(sdwe), .pin_dir(pin_dir),
    .held_sense_event(det), .irq(irq)
  );

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic chk(input string name, input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      err_count++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    req.wr <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] exp, input string name);
    @(posedge clk);
    req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    req.rd <= 1'b0;
    #1;
    chk(name, rdata, exp);
  endtask

  task automatic settle;
    repeat (6) @(posedge clk);
    #1;
  endtask

  task automatic summarize;
    $display("errors %0d comparisons %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset;
    logic [11:0] ofs [9] = '{12'h014, 12'h018, 12'h01C, 12'h020, 12'h024, 12'h028, 12'h040, 12'h044, 12'h030};
    foreach (ofs[i])
      rd(ofs[i], `GDS_RST_WORD, "reset value");
    chk("pin_dir", pin_dir, 32'h0);
  endtask

  task automatic t_dir;
    wr(`GDS_OFS_DIR, 32'hA5A50F0F);
    rd(`GDS_OFS_DIR, 32'hA5A50F0F, "dir");
    chk("pin_dir", pin_dir, 32'hA5A50F0F);
    wr(`GDS_OFS_DIR_SET, 32'h0000F0F0);
    rd(`GDS_OFS_DIR_SET, 32'hA5A5FFFF, "set alias");
    wr(`GDS_OFS_DIR_CLR, 32'hA500000F);
    rd(`GDS_OFS_DIR_CLR, 32'h00A5FFF0, "clear alias");
    @(posedge clk);
    sdw  <= 32'h01000000;
    sdwe <= 32'h01000010;
    @(posedge clk);
    sdwe <= 32'h0;
    rd(`GDS_OFS_DIR, 32'h01A5FFE0, "setup dir");
  endtask

  task automatic t_sense;
    @(posedge clk);
    want  <= 32'h2;
    settle();
    @(posedge clk);
    sense <= 64'h4E;
    settle();
    rd(`GDS_OFS_SENSE_HIT, 32'h0, "hit idle");
    chk("nonsec", {31'h0, det.nonsec}, 32'h0);
    want <= 32'hD;
    settle();
    rd(`GDS_OFS_SENSE_HIT, 32'h3, "hit met");
    chk("nonsec", {31'h0, det.nonsec}, 32'h1);
    wr(`GDS_OFS_SENSE_HIT, 32'h1);
    rd(`GDS_OFS_SENSE_HIT, 32'h3, "hit held");
    wr(`GDS_OFS_SENSE_HIT, 32'h0);
    rd(`GDS_OFS_SENSE_HIT, 32'h3, "hit zero wr");
    want <= 32'h2;
    settle();
    chk("nonsec", {31'h0, det.nonsec}, 32'h0);
    wr(`GDS_OFS_NS_STYLE, 32'h1);
    settle();
    chk("nonsec", {31'h0, det.nonsec}, 32'h1);
    wr(`GDS_OFS_SENSE_HIT, 32'h3);
    rd(`GDS_OFS_SENSE_HIT, 32'h0, "hit clr");
    settle();
    chk("nonsec", {31'h0, det.nonsec}, 32'h0);
  endtask

  task automatic t_secure;
    @(posedge clk);
    sec <= 32'h2;
    wr(`GDS_OFS_S_STYLE, 32'h1);
    want <= 32'h0;
    settle();
    want <= 32'h2;
    settle();
    chk("sec", {31'h0, det.sec}, 32'h1);
    chk("nonsec", {31'h0, det.nonsec}, 32'h0);
    rd(`GDS_OFS_NS_STYLE, 32'h1, "ns style");
    wr(`GDS_OFS_S_STYLE, 32'h0);
    settle();
    chk("sec", {31'h0, det.sec}, 32'h0);
    wr(`GDS_OFS_SENSE_HIT, 32'h2);
    rd(`GDS_OFS_SENSE_HIT, 32'h0, "hit sec");
  endtask

  task automatic t_irq;
    wr(`GDS_OFS_IRQ_STATUS, 32'h3);
    rd(`GDS_OFS_IRQ_STATUS, 32'h0, "status clr");
    want <= 32'h3;
    settle();
    rd(`GDS_OFS_IRQ_STATUS, 32'h1, "status set");
    chk("irq", {31'h0, irq}, 32'h0);
    wr(`GDS_OFS_IRQ_MASK, 32'h2);
    chk("irq", {31'h0, irq}, 32'h0);
    wr(`GDS_OFS_IRQ_MASK, 32'h1);
    chk("irq", {31'h0, irq}, 32'h1);
    wr(`GDS_OFS_IRQ_STATUS, 32'h1);
    chk("irq", {31'h0, irq}, 32'h0);
  endtask

  task automatic t_freeze;
    @(posedge clk);
    ce <= 1'b0;
    wr(`GDS_OFS_DIR, 32'hFFFFFFFF);
    @(posedge clk);
    ce <= 1'b1;
    rd(`GDS_OFS_DIR, 32'h01A5FFE0, "dir frozen");
    chk("pin_dir", pin_dir, 32'h01A5FFE0);
  endtask

  // Hang guard well beyond the scenario length
  initial
  begin
    #(50 * 20000);
    err_count++;
    summarize();
  end

  initial
  begin
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    t_reset();
    t_dir();
    t_sense();
    t_secure();
    t_irq();
    t_freeze();
    summarize();
  end
endmodule
